// [rtl/pssr_pkg.sv]
// Package of shared constants and types for the pipelined synchronous memory.
package pssr_pkg;
  localparam int PSSR_ADDR_W = 12;
  localparam int PSSR_DATA_W = 12;
  localparam int PSSR_DEPTH = 4096;
  localparam int PSSR_CLK_PERIOD_NS = 10;
  // Longest times; edge to valid is also rounded down to whole cycles of the clock, at least one.
  localparam int PSSR_EDGE_TO_VALID_NS = 10;
  localparam int PSSR_EDGE_TO_VALID_CYC = (PSSR_EDGE_TO_VALID_NS / PSSR_CLK_PERIOD_NS) < 1 ? 1 :
    (PSSR_EDGE_TO_VALID_NS / PSSR_CLK_PERIOD_NS);
  localparam int PSSR_ENABLE_TO_VALID_NS = 10;
  localparam int PSSR_DISABLE_TO_FLOAT_NS = 10;
  localparam int PSSR_EDGE_TO_FLOAT_NS = 10;
  // Least cycle period of the slower grade; the controller spaces its cycles by this.
  localparam int PSSR_CYCLE_PERIOD_NS = 20;
  localparam int PSSR_CYCLE_PERIOD_CYC = (PSSR_CYCLE_PERIOD_NS + PSSR_CLK_PERIOD_NS - 1)
    / PSSR_CLK_PERIOD_NS;
  localparam logic [PSSR_ADDR_W-1:0] PSSR_ADDR_RESET = 12'h000;
  localparam logic [PSSR_DATA_W-1:0] PSSR_DATA_RESET = 12'h000;
  typedef enum logic [1:0] {PSSR_IDLE, PSSR_ISSUE, PSSR_WAIT} pssr_ctl_state_t;
endpackage : pssr_pkg

// [rtl/pssr_if.sv]
// Interface joining the memory device and its controller.
`timescale 1ns/10ps
`default_nettype none
interface pssr_if;
  import pssr_pkg::*;
  // Edge timing enable: one-cycle pulse registered from the controller's ISSUE state.
  logic edge_stb;
  logic [PSSR_ADDR_W-1:0] location_bus;
  logic [PSSR_DATA_W-1:0] input_bus;
  logic write_n;
  logic output_enable_n;
  logic [PSSR_DATA_W-1:0] output_bus;
  logic output_bus_oe;
  modport device (input edge_stb, input location_bus, input input_bus, input write_n,
    input output_enable_n, output output_bus, output output_bus_oe);
  modport ctrl (output edge_stb, output location_bus, output input_bus, output write_n,
    output output_enable_n, input output_bus, input output_bus_oe);
endinterface : pssr_if
`default_nettype wire

// [rtl/pssr_device.sv]
// Device end: 4096 x 12 synchronous memory with registered output and output enable.
// Notes on behaviour
// - 4096 words of 12 bits each
// - Address, data, write select registered each edge
// - Write select low means write cycle
// - Write select high means read cycle
// - Output register gives one-cycle read latency
// - Output shows last read, writes ignored
// - Read data valid within 10 ns
// - Output enable acts without the clock; here registered in drive_reg, one clock late
// - Enable low gives data within 10 ns
// - Enable high floats bus within 10 ns
// - Write edge floats bus within 10 ns
// - Enable ignored after first write of run
// - Write pulse made internally from edge
// - Controller keeps period at least 18/20 ns
// - Separate input and output buses
// - Outputs float after power-up until read
// - Controller holds clock steady at power-up
// - Controller keeps inputs stable every edge
`timescale 1ns/10ps
`default_nettype none
module pssr_device
  import pssr_pkg::*;
#(
  parameter int DEPTH = PSSR_DEPTH
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Memory pins
  pssr_if.device MEM
);
  // no reset here, so a word never written reads back undefined.
  logic [PSSR_DATA_W-1:0] array_mem [DEPTH];

  // Captured pins of the current memory cycle.
  logic [PSSR_ADDR_W-1:0] addr_reg;
  logic [PSSR_ADDR_W-1:0] addr_next;
  logic [PSSR_DATA_W-1:0] din_reg;
  logic [PSSR_DATA_W-1:0] din_next;
  logic wr_reg;
  logic wr_next;
  logic cap_reg;
  logic cap_next;
  logic [PSSR_ADDR_W-1:0] rd_addr_reg;
  logic [PSSR_ADDR_W-1:0] rd_addr_next;

  // Output register and the state that gates its drivers.
  logic [PSSR_DATA_W-1:0] q_reg;
  logic [PSSR_DATA_W-1:0] q_next;
  logic read_seen_reg;
  logic read_seen_next;
  logic run_reg;
  logic run_next;
  logic drive_reg;
  logic drive_next;

  // Decoded cycle kinds and array access.
  logic edge_now;
  logic wr_now;
  logic rd_now;
  logic write_pulse;
  logic read_load;
  logic [PSSR_DATA_W-1:0] fetch_data;
  logic oe_active;

  // One enable pulse stands for one rising edge of the memory clock.
  assign edge_now = MEM.edge_stb;

  assign wr_now = edge_now & ~MEM.write_n;

  assign rd_now = edge_now & MEM.write_n;

  // capture on edge
  // Between memory edges the registers hold, so the pins may change freely then.
  assign addr_next = edge_now ? MEM.location_bus : addr_reg;
  assign din_next = edge_now ? MEM.input_bus : din_reg;
  assign wr_next = edge_now ? ~MEM.write_n : wr_reg;
  assign cap_next = edge_now;

  // internal write pulse
  // The pulse works from the captured registers, never from the pins themselves.
  assign write_pulse = cap_reg & wr_reg;

  // read location held
  // A separate read location keeps a later write capture from moving the read selection.
  assign rd_addr_next = rd_now ? MEM.location_bus : rd_addr_reg;

  assign read_load = cap_reg & ~wr_reg;
  assign fetch_data = array_mem[rd_addr_reg];

  assign q_next = read_load ? fetch_data : q_reg;
  assign read_seen_next = read_seen_reg | read_load;

  // write run tracking
  // A run of writes ends only at the next read, whatever the enable does meanwhile.
  assign run_next = wr_now ? 1'b1 : (rd_now ? 1'b0 : run_reg);

  assign oe_active = ~MEM.output_enable_n & read_seen_reg & ~run_reg;

  assign drive_next = oe_active & ~wr_now;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      addr_reg <= PSSR_ADDR_RESET;
    end else begin
      addr_reg <= addr_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      din_reg <= PSSR_DATA_RESET;
    end else begin
      din_reg <= din_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      wr_reg <= 1'b0;
    end else begin
      wr_reg <= wr_next;
    end
  end

  // Marks the cycle right after a memory edge.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      cap_reg <= 1'b0;
    end else begin
      cap_reg <= cap_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      rd_addr_reg <= PSSR_ADDR_RESET;
    end else begin
      rd_addr_reg <= rd_addr_next;
    end
  end

  // array write
  // Keeping the array free of reset lets it map onto plain memory cells.
  always_ff @(posedge CLK) begin
    if (write_pulse) begin
      array_mem[addr_reg] <= din_reg;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      q_reg <= PSSR_DATA_RESET;
    end else begin
      q_reg <= q_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      read_seen_reg <= 1'b0;
    end else begin
      read_seen_reg <= read_seen_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      run_reg <= 1'b0;
    end else begin
      run_reg <= run_next;
    end
  end

  // drive register
  // One clock of 10 ns covers each of these delays, at the cost of no faster response.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      drive_reg <= 1'b0;
    end else begin
      drive_reg <= drive_next;
    end
  end

  assign MEM.output_bus = q_reg;
  assign MEM.output_bus_oe = drive_reg;
endmodule : pssr_device
`default_nettype wire

// [rtl/pssr_ctrl.sv]
// Controller end: issues read and write cycles to the memory and returns read data.
`timescale 1ns/10ps
`default_nettype none
module pssr_ctrl
  import pssr_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // User request
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [PSSR_ADDR_W-1:0] REQ_ADDR,
  input wire logic [PSSR_DATA_W-1:0] REQ_DATA,
  input wire logic READ_ENABLE,
  output logic REQ_READY,
  // Read answer
  output logic RSP_VALID,
  output logic [PSSR_DATA_W-1:0] RSP_DATA,
  // Memory pins
  pssr_if.ctrl MEM
);
  pssr_ctl_state_t state_reg, state_next;
  logic stb_reg;
  logic wn_reg;
  logic [PSSR_ADDR_W-1:0] addr_reg;
  logic [PSSR_DATA_W-1:0] data_reg;
  logic oen_reg;
  logic [3:0] wait_reg;
  logic rd_pend_reg;
  wire logic take = (state_reg == PSSR_IDLE) & REQ_VALID;
  wire logic rsp_hit = (state_reg == PSSR_WAIT) & (wait_reg == 4'h0) & rd_pend_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PSSR_IDLE: if (REQ_VALID) state_next = PSSR_ISSUE;
      PSSR_ISSUE: state_next = PSSR_WAIT;
      PSSR_WAIT: if (wait_reg == 4'h0) state_next = PSSR_IDLE;
      default: state_next = PSSR_IDLE;
    endcase
  end

  // inputs held stable, strobes spaced, none before reset ends.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      state_reg <= PSSR_IDLE;
      stb_reg <= 1'b0;
      wn_reg <= 1'b1;
      addr_reg <= PSSR_ADDR_RESET;
      data_reg <= PSSR_DATA_RESET;
      oen_reg <= 1'b1;
      wait_reg <= 4'h0;
      rd_pend_reg <= 1'b0;
      REQ_READY <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_DATA <= PSSR_DATA_RESET;
    end else begin
      state_reg <= state_next;
      oen_reg <= ~READ_ENABLE;
      stb_reg <= (state_reg == PSSR_ISSUE);
      REQ_READY <= (state_next == PSSR_IDLE) & ~take;
      RSP_VALID <= rsp_hit;
      if (rsp_hit) RSP_DATA <= MEM.output_bus;
      if (take) begin
        wn_reg <= ~REQ_WRITE;
        addr_reg <= REQ_ADDR;
        data_reg <= REQ_DATA;
        rd_pend_reg <= ~REQ_WRITE;
      end
      if (state_reg == PSSR_ISSUE) begin
        wait_reg <= 4'(PSSR_CYCLE_PERIOD_CYC + 1);
      end else if (wait_reg != 4'h0) begin
        wait_reg <= wait_reg - 4'h1;
      end
    end
  end

  assign MEM.edge_stb = stb_reg;
  assign MEM.write_n = wn_reg;
  assign MEM.location_bus = addr_reg;
  assign MEM.input_bus = data_reg;
  assign MEM.output_enable_n = oen_reg;
endmodule : pssr_ctrl
`default_nettype wire

// [test/pssr_assertions.sv]
// Checker of the memory pins between the controller and the device.
`timescale 1ns/10ps
`default_nettype none
module pssr_assertions
  import pssr_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Memory pins
  input wire logic edge_stb,
  input wire logic [PSSR_ADDR_W-1:0] location_bus,
  input wire logic [PSSR_DATA_W-1:0] input_bus,
  input wire logic write_n,
  input wire logic output_enable_n,
  input wire logic [PSSR_DATA_W-1:0] output_bus,
  input wire logic output_bus_oe
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // Remembers whether the last strobe was a read, since a write blocks the drivers until then.
  logic rd_seen_reg;
  always_ff @(posedge CLK) begin
    if (!RESETN) rd_seen_reg <= 1'b0;
    else if (edge_stb) rd_seen_reg <= write_n;
  end
  sequence s_rd; edge_stb && write_n; endsequence
  sequence s_wr; edge_stb && !write_n; endsequence
  property p_wr_float; s_wr |-> ##[1:2] !output_bus_oe; endproperty
  a_wr_float: assert property (p_wr_float) else $error("bus driven after write");
  property p_dis_float; output_enable_n |=> !output_bus_oe; endproperty
  a_dis_float: assert property (p_dis_float) else $error("bus driven while disabled");
  property p_en_cause; $rose(output_bus_oe) |-> $past(!output_enable_n); endproperty
  a_en_cause: assert property (p_en_cause) else $error("drive without enable");
  property p_rd_first; $rose(output_bus_oe) |-> rd_seen_reg; endproperty
  a_rd_first: assert property (p_rd_first) else $error("drive without read");
  property p_wr_hold; s_wr |=> $stable(output_bus) [*3]; endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write changed output");
  property p_stb_gap; edge_stb |=> !edge_stb; endproperty
  a_stb_gap: assert property (p_stb_gap) else $error("strobes too close");
  property p_en_valid; s_rd ##1 (!output_enable_n && rd_seen_reg) [*3] |-> output_bus_oe;
  endproperty
  a_en_valid: assert property (p_en_valid) else $error("read data not driven");
  property p_q_load; $changed(output_bus) |-> $past(edge_stb && write_n, 2); endproperty
  a_q_load: assert property (p_q_load) else $error("output changed off read");
endmodule : pssr_assertions
`default_nettype wire

// [test/pssr_test.sv]
// Testbench joining controller and device and checking reads, writes and drivers.
`timescale 1ns/10ps
`default_nettype none
module pssr_test
  import pssr_pkg::*;
;
  logic CLK, RESETN, REQ_VALID, REQ_WRITE, READ_ENABLE, REQ_READY, RSP_VALID;
  logic [PSSR_ADDR_W-1:0] REQ_ADDR;
  logic [PSSR_DATA_W-1:0] REQ_DATA, RSP_DATA;
  int checks = 0, n_mismatch = 0, cyc = 0;
  `define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end
  pssr_if pssr_if_i();
  pssr_device pssr_device_i (.CLK(CLK), .RESETN(RESETN), .MEM(pssr_if_i));
  pssr_ctrl pssr_ctrl_i (.CLK(CLK), .RESETN(RESETN), .REQ_VALID(REQ_VALID),
    .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_DATA(REQ_DATA),
    .READ_ENABLE(READ_ENABLE), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
    .RSP_DATA(RSP_DATA), .MEM(pssr_if_i));
  pssr_assertions pssr_assertions_i (.CLK(CLK), .RESETN(RESETN), .edge_stb(pssr_if_i.edge_stb),
    .location_bus(pssr_if_i.location_bus), .input_bus(pssr_if_i.input_bus),
    .write_n(pssr_if_i.write_n), .output_enable_n(pssr_if_i.output_enable_n),
    .output_bus(pssr_if_i.output_bus), .output_bus_oe(pssr_if_i.output_bus_oe));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  // One request; a read is judged against the expected word when it returns.
  task automatic op(input logic w, input logic [11:0] a, input logic [11:0] d);
    int n;
    n = 0;
    do @(posedge CLK); while (REQ_READY !== 1'b1 && ++n < 40);
    REQ_VALID <= 1'b1;
    REQ_WRITE <= w;
    REQ_ADDR <= a;
    REQ_DATA <= d;
    @(posedge CLK);
    REQ_VALID <= 1'b0;
    do @(posedge CLK); while (pssr_if_i.edge_stb !== 1'b1 && ++n < 40);
    `CHK("location", a, pssr_if_i.location_bus)
    `CHK("write_n", !w, pssr_if_i.write_n)
    `CHK("ready_busy", 1'b0, REQ_READY)
    if (w) begin
      `CHK("input", d, pssr_if_i.input_bus)
    end else begin
      do @(posedge CLK); while (RSP_VALID !== 1'b1 && ++n < 40);
      `CHK("rsp_valid", 1'b1, RSP_VALID)
      `CHK("rsp_data", d, RSP_DATA)
      `CHK("oe_rsp", 1'b1, pssr_if_i.output_bus_oe)
    end
  endtask : op
  task automatic t_rw;
    READ_ENABLE <= 1'b1;
    op(1'b1, 12'h000, 12'hA5C);
    op(1'b1, 12'hFFF, 12'h3C3);
    op(1'b1, 12'h7FF, 12'hFFF);
    op(1'b0, 12'h000, 12'hA5C);
    op(1'b0, 12'h7FF, 12'hFFF);
  endtask : t_rw
  task automatic t_float;
    READ_ENABLE <= 1'b1;
    op(1'b0, 12'hFFF, 12'h3C3);
    repeat (2) @(posedge CLK);
    `CHK("oe_read", 1'b1, pssr_if_i.output_bus_oe)
    op(1'b1, 12'h001, 12'h111);
    repeat (3) @(posedge CLK);
    `CHK("oe_write", 1'b0, pssr_if_i.output_bus_oe)
    op(1'b1, 12'h002, 12'h222);
    repeat (3) @(posedge CLK);
    `CHK("oe_run", 1'b0, pssr_if_i.output_bus_oe)
    `CHK("q_held", 12'h3C3, pssr_if_i.output_bus)
    op(1'b0, 12'h001, 12'h111);
  endtask : t_float
  task automatic t_enable;
    repeat (3) @(posedge CLK);
    READ_ENABLE <= 1'b0;
    repeat (3) @(posedge CLK);
    `CHK("oe_off", 1'b0, pssr_if_i.output_bus_oe)
    READ_ENABLE <= 1'b1;
    repeat (3) @(posedge CLK);
    `CHK("oe_on", 1'b1, pssr_if_i.output_bus_oe)
    `CHK("q_on", 12'h111, pssr_if_i.output_bus)
  endtask : t_enable
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    {RESETN, REQ_VALID, REQ_WRITE, READ_ENABLE, REQ_ADDR, REQ_DATA} = '0;
    repeat (4) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    `CHK("oe_reset", 1'b0, pssr_if_i.output_bus_oe)
    t_rw();
    t_float();
    t_enable();
    complete_run();
  end
endmodule : pssr_test
`default_nettype wire
